// File: logic/nfc_host.sv
/*
 * nand bus host controller with its write-data fifo.
 * assumes one 10 mhz clock, pins driven from flip-flops, and an
 * external wire resolver for the shared i/o lines.
 */
// Notes on behaviour
// - column cycles go out before row cycles.
// - erase sends row cycles only.
// - each address goes least significant byte first.
// - unused top address bits driven zero.
// - program pages ascending within a block; checked only against the last programmed block.
// - every cycle: select low, strobe pulsed.
// - command and address selects mark cycles.
// - protect changes only idle, then settle.
// - no commands during power-on busy.
// - protect held low through power-up.
`timescale 1ns/1ps
module nfc_fifo #(
    parameter int W = 8,
    parameter int D = 32
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // filling side
    input wire logic [W-1:0] i_in_data,
    input wire logic i_in_valid,
    output logic o_in_ready,
    // draining side
    output logic [W-1:0] o_out_data,
    output logic o_out_valid,
    input wire logic i_out_ready
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_reg [D];
    logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
    logic [AW:0] cnt_reg, cnt_next;
    logic rdy_reg, rdy_next, push, pop;
    // pointer and fill level update
    always_comb
    begin
        push = i_in_valid && rdy_reg;
        pop = i_out_ready && (cnt_reg != '0);
        wp_next = push ? AW'(wp_reg + 1'b1) : wp_reg;
        rp_next = pop ? AW'(rp_reg + 1'b1) : rp_reg;
        cnt_next = cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        rdy_next = cnt_next != (AW+1)'(D);
    end
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            wp_reg <= '0;
            rp_reg <= '0;
            cnt_reg <= '0;
            rdy_reg <= 1'b0;
        end
        else
        begin
            wp_reg <= wp_next;
            rp_reg <= rp_next;
            cnt_reg <= cnt_next;
            rdy_reg <= rdy_next;
        end
    end
    // storage, no reset needed
    always_ff @(posedge i_clk)
    begin
        if (push)
            mem_reg[wp_reg] <= i_in_data;
    end
    assign o_in_ready = rdy_reg;
    assign o_out_valid = cnt_reg != '0;
    assign o_out_data = mem_reg[rp_reg];
endmodule

module nfc_host #(
    parameter int POR_CYC = nfc_pkg::POR_CYC
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // user command port
    input wire logic i_cmd_valid,
    input wire nfc_pkg::nfc_op_t i_cmd_op,
    input wire logic [nfc_pkg::COL_W-1:0] i_col,
    input wire logic [nfc_pkg::ROW_W-1:0] i_row,
    input wire logic [nfc_pkg::LEN_W-1:0] i_len,
    input wire logic i_protect,
    output logic o_cmd_ready,
    output logic o_done,
    output logic o_err,
    // user data
    input wire logic [7:0] i_wr_data,
    input wire logic i_wr_valid,
    output logic o_wr_ready,
    output logic [7:0] o_rd_data,
    output logic o_rd_valid,
    // flash pins
    output logic o_ce_n,
    output logic o_cle,
    output logic o_ale,
    output logic o_we_n,
    output logic o_re_n,
    output logic o_wp_n,
    output logic [7:0] o_io,
    output logic o_io_oe,
    input wire logic [7:0] i_io,
    input wire logic i_rb_n
);
    typedef enum logic [3:0] {S_POR, S_IDLE, S_WP, S_CMD1, S_ADR, S_WDAT, S_CMD2, S_GUARD, S_BUSY, S_RDAT,
        S_END} nfc_st_t;
    nfc_st_t st_reg, st_next;
    nfc_pkg::nfc_op_t op_reg, op_next;
    logic [1:0] ph_reg, ph_next;
    logic [2:0] acnt_reg, acnt_next;
    logic [15:0] cnt_reg, cnt_next;
    logic [nfc_pkg::LEN_W-1:0] bcnt_reg, bcnt_next;
    logic [nfc_pkg::COL_W-1:0] col_reg, col_next;
    logic [nfc_pkg::ROW_W-1:0] row_reg, row_next;
    logic [nfc_pkg::BLK_W-1:0] lblk_reg, lblk_next;
    logic [nfc_pkg::PG_W-1:0] lpg_reg, lpg_next;
    logic lv_reg, lv_next;
    logic ce_n_next, cle_next, ale_next, we_n_next, re_n_next, wp_n_next, oe_next;
    logic rdy_next, done_next, err_next, rdv_next;
    logic [7:0] io_next, rdd_next, abyte, fifo_data;
    logic [7:0] io_s1, io_s2;
    logic rb_s1, rb_s2, fifo_valid, fifo_pop, order_bad;
    // ****************
    // pin input synchronisers
    // ****************
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            io_s1 <= 8'h00;
            io_s2 <= 8'h00;
            rb_s1 <= 1'b0;
            rb_s2 <= 1'b0;
        end
        else
        begin
            io_s1 <= i_io;
            io_s2 <= io_s1;
            rb_s1 <= i_rb_n;
            rb_s2 <= rb_s1;
        end
    end
    // ****************
    // write data buffer
    // ****************
    assign fifo_pop = (st_reg == S_WDAT) && (ph_reg == 2'h0) && fifo_valid;
    nfc_fifo #(.W(nfc_pkg::FIFO_W), .D(nfc_pkg::FIFO_D)) u_fifo (
        .i_clk(i_clk), .i_rstn(i_rstn),
        .i_in_data(i_wr_data), .i_in_valid(i_wr_valid), .o_in_ready(o_wr_ready),
        .o_out_data(fifo_data), .o_out_valid(fifo_valid), .i_out_ready(fifo_pop));
    // ****************
    // address bytes and page order check
    // ****************
    always_comb
    begin
        case (acnt_reg)
            3'h0: abyte = col_reg[7:0];
            3'h1: abyte = {3'h0, col_reg[12:8]};
            3'h2: abyte = row_reg[7:0];
            3'h3: abyte = row_reg[15:8];
            default: abyte = {6'h00, row_reg[17:16]};
        endcase
        order_bad = (i_cmd_op == nfc_pkg::OP_PROG) && lv_reg
            && (i_row[nfc_pkg::BLK_LSB +: nfc_pkg::BLK_W] == lblk_reg)
            && (i_row[nfc_pkg::PG_LSB +: nfc_pkg::PG_W] <= lpg_reg);
    end
    // ****************
    // sequencer next state
    // ****************
    always_comb
    begin
        st_next = st_reg;
        op_next = op_reg;
        ph_next = ph_reg;
        acnt_next = acnt_reg;
        cnt_next = cnt_reg;
        bcnt_next = bcnt_reg;
        col_next = col_reg;
        row_next = row_reg;
        lblk_next = lblk_reg;
        lpg_next = lpg_reg;
        lv_next = lv_reg;
        ce_n_next = o_ce_n;
        cle_next = 1'b0;
        ale_next = 1'b0;
        we_n_next = 1'b1;
        re_n_next = 1'b1;
        wp_n_next = o_wp_n;
        oe_next = o_io_oe;
        io_next = o_io;
        rdd_next = o_rd_data;
        done_next = 1'b0;
        err_next = 1'b0;
        rdv_next = 1'b0;
        case (st_reg)
            S_POR:
            begin
                // no cycles and protect low until power-up busy ends
                wp_n_next = 1'b0;
                if (cnt_reg != 16'(POR_CYC - 1))
                    cnt_next = cnt_reg + 16'h1;
                else if (rb_s2)
                    st_next = S_IDLE;
            end
            S_IDLE:
            begin
                cnt_next = 16'h0;
                ph_next = 2'h0;
                if (i_protect == o_wp_n)
                begin
                    wp_n_next = !i_protect;
                    st_next = S_WP;
                end
                else if (i_cmd_valid && o_cmd_ready)
                begin
                    if (order_bad || (!o_wp_n && (i_cmd_op == nfc_pkg::OP_PROG
                        || i_cmd_op == nfc_pkg::OP_ERASE)))
                        err_next = 1'b1;
                    else
                    begin
                        op_next = i_cmd_op;
                        col_next = i_col;
                        row_next = i_row;
                        bcnt_next = (i_cmd_op == nfc_pkg::OP_STATUS) ? nfc_pkg::LEN_W'(1) : i_len;
                        ce_n_next = 1'b0;
                        st_next = S_CMD1;
                    end
                end
            end
            S_WP:
            begin
                cnt_next = cnt_reg + 16'h1;
                if (cnt_reg == 16'(nfc_pkg::SETTLE_CYC - 1))
                    st_next = S_IDLE;
            end
            S_CMD1, S_ADR, S_WDAT, S_CMD2:
            begin
                // strobe low one cycle, rise latches the byte
                oe_next = 1'b1;
                if (ph_reg == 2'h0 && (st_reg != S_WDAT || fifo_valid))
                begin
                    we_n_next = 1'b0;
                    ph_next = 2'h1;
                    cle_next = (st_reg == S_CMD1) || (st_reg == S_CMD2);
                    ale_next = st_reg == S_ADR;
                    if (st_reg == S_ADR)
                        io_next = abyte;
                    else if (st_reg == S_WDAT)
                        io_next = fifo_data;
                    else if (st_reg == S_CMD2)
                        io_next = (op_reg == nfc_pkg::OP_READ) ? nfc_pkg::OPC_READ2
                            : (op_reg == nfc_pkg::OP_PROG) ? nfc_pkg::OPC_PROG2 : nfc_pkg::OPC_ERASE2;
                    else
                        case (op_reg)
                            nfc_pkg::OP_READ: io_next = nfc_pkg::OPC_READ1;
                            nfc_pkg::OP_PROG: io_next = nfc_pkg::OPC_PROG1;
                            nfc_pkg::OP_ERASE: io_next = nfc_pkg::OPC_ERASE1;
                            nfc_pkg::OP_STATUS: io_next = nfc_pkg::OPC_STATUS;
                            default: io_next = nfc_pkg::OPC_RESET;
                        endcase
                end
                else if (ph_reg == 2'h1)
                begin
                    ph_next = 2'h0;
                    cle_next = o_cle;
                    ale_next = o_ale;
                    cnt_next = 16'h0;
                    case (st_reg)
                        S_CMD1:
                        begin
                            acnt_next = (op_reg == nfc_pkg::OP_ERASE) ? nfc_pkg::ADR_ROW0
                                : nfc_pkg::ADR_COL0;
                            if (op_reg == nfc_pkg::OP_STATUS)
                                st_next = S_RDAT;
                            else if (op_reg == nfc_pkg::OP_RESET)
                                st_next = S_GUARD;
                            else
                                st_next = S_ADR;
                        end
                        S_ADR:
                        begin
                            acnt_next = acnt_reg + 3'h1;
                            if (acnt_reg == nfc_pkg::ADR_LAST)
                                st_next = (op_reg == nfc_pkg::OP_PROG && bcnt_reg != '0) ? S_WDAT : S_CMD2;
                        end
                        S_WDAT:
                        begin
                            bcnt_next = bcnt_reg - nfc_pkg::LEN_W'(1);
                            if (bcnt_reg == nfc_pkg::LEN_W'(1))
                                st_next = S_CMD2;
                        end
                        default: st_next = S_GUARD;
                    endcase
                end
            end
            S_GUARD:
            begin
                // let ready/busy fall before it is watched
                oe_next = 1'b0;
                cnt_next = cnt_reg + 16'h1;
                if (cnt_reg == 16'(nfc_pkg::GUARD_CYC - 1))
                    st_next = S_BUSY;
            end
            S_BUSY:
            begin
                if (rb_s2)
                    st_next = (op_reg == nfc_pkg::OP_READ && bcnt_reg != '0) ? S_RDAT : S_END;
            end
            S_RDAT:
            begin
                // read beat: strobe low two cycles, sample after sync
                oe_next = 1'b0;
                ph_next = ph_reg + 2'h1;
                re_n_next = ph_reg[1];
                if (ph_reg == 2'h3)
                begin
                    rdd_next = io_s2;
                    rdv_next = 1'b1;
                    bcnt_next = bcnt_reg - nfc_pkg::LEN_W'(1);
                    if (bcnt_reg == nfc_pkg::LEN_W'(1))
                        st_next = S_END;
                end
            end
            S_END:
            begin
                ce_n_next = 1'b1;
                done_next = 1'b1;
                st_next = S_IDLE;
                if (op_reg == nfc_pkg::OP_PROG)
                begin
                    lv_next = 1'b1;
                    lblk_next = row_reg[nfc_pkg::BLK_LSB +: nfc_pkg::BLK_W];
                    lpg_next = row_reg[nfc_pkg::PG_LSB +: nfc_pkg::PG_W];
                end
                else if (op_reg == nfc_pkg::OP_ERASE && row_reg[nfc_pkg::BLK_LSB +: nfc_pkg::BLK_W] == lblk_reg)
                    lv_next = 1'b0;
            end
            default: st_next = S_IDLE;
        endcase
        rdy_next = (st_next == S_IDLE) && !(st_reg == S_IDLE && i_cmd_valid && o_cmd_ready);
    end
    // ****************
    // sequencer registers
    // ****************
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            st_reg <= S_POR;
            op_reg <= nfc_pkg::OP_READ;
            ph_reg <= 2'h0;
            acnt_reg <= 3'h0;
            cnt_reg <= 16'h0;
            bcnt_reg <= '0;
            col_reg <= '0;
            row_reg <= '0;
            lblk_reg <= '0;
            lpg_reg <= '0;
            lv_reg <= 1'b0;
            {o_ce_n, o_cle, o_ale, o_we_n, o_re_n, o_wp_n, o_io_oe} <= 7'h78;
            o_io <= 8'h00;
            o_rd_data <= 8'h00;
            {o_cmd_ready, o_done, o_err, o_rd_valid} <= 4'h0;
        end
        else
        begin
            st_reg <= st_next;
            op_reg <= op_next;
            ph_reg <= ph_next;
            acnt_reg <= acnt_next;
            cnt_reg <= cnt_next;
            bcnt_reg <= bcnt_next;
            col_reg <= col_next;
            row_reg <= row_next;
            lblk_reg <= lblk_next;
            lpg_reg <= lpg_next;
            lv_reg <= lv_next;
            {o_ce_n, o_cle, o_ale, o_we_n, o_re_n, o_wp_n, o_io_oe} <=
                {ce_n_next, cle_next, ale_next, we_n_next, re_n_next, wp_n_next, oe_next};
            o_io <= io_next;
            o_rd_data <= rdd_next;
            {o_cmd_ready, o_done, o_err, o_rd_valid} <= {rdy_next, done_next, err_next, rdv_next};
        end
    end
    // ****************
    // checks
    // ****************
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);
    property p_we_ce;
        !o_we_n |-> !o_ce_n && o_re_n;
    endproperty
    a_we_ce: assert property (p_we_ce)
        else $error("strobe without select");
    property p_lat_excl;
        !o_we_n |-> !(o_cle && o_ale) && o_io_oe;
    endproperty
    a_lat_excl: assert property (p_lat_excl)
        else $error("both latch selects high");
    property p_col_first;
        st_reg == S_ADR && ph_reg == 2'h0 && acnt_reg == 3'h0 |=> o_ale && !o_we_n && o_io == col_reg[7:0];
    endproperty
    a_col_first: assert property (p_col_first)
        else $error("column low byte not first");
    property p_row_top;
        st_reg == S_ADR && ph_reg == 2'h0 && acnt_reg == 3'h4 |=> o_io == {6'h00, row_reg[17:16]};
    endproperty
    a_row_top: assert property (p_row_top)
        else $error("unused top row bits not zero");
    property p_lsb_first;
        st_reg == S_ADR && ph_reg == 2'h0 && acnt_reg == 3'h2 |=> o_io == row_reg[7:0] ##2 o_io == row_reg[15:8];
    endproperty
    a_lsb_first: assert property (p_lsb_first)
        else $error("row bytes out of order");
    property p_erase_row;
        st_reg == S_CMD1 && ph_reg == 2'h1 && op_reg == nfc_pkg::OP_ERASE |=> acnt_reg == 3'h2;
    endproperty
    a_erase_row: assert property (p_erase_row)
        else $error("erase sent a column cycle");
    property p_por_quiet;
        st_reg == S_POR |-> o_ce_n && o_we_n;
    endproperty
    a_por_quiet: assert property (p_por_quiet)
        else $error("bus cycle during power-up busy");
    property p_por_wp;
        st_reg == S_POR |-> !o_wp_n;
    endproperty
    a_por_wp: assert property (p_por_wp)
        else $error("protect released during power-up");
    property p_wp_idle;
        $changed(o_wp_n) |-> o_ce_n && st_reg == S_WP && cnt_reg == 16'h0;
    endproperty
    a_wp_idle: assert property (p_wp_idle)
        else $error("protect changed outside idle");
    property p_order;
        st_reg == S_IDLE && i_cmd_valid && o_cmd_ready && order_bad && i_protect != o_wp_n |=> o_err && st_reg == S_IDLE;
    endproperty
    a_order: assert property (p_order)
        else $error("page order not enforced");
endmodule

// File: logic/nfc_pkg.sv
/*
 * shared constants for the nand bus host controller: opcodes,
 * address field layout, timing counts and fifo shape.
 * assumes a 10 mhz system clock and a byte-wide flash device.
 */
package nfc_pkg;
    // ****************
    // timing
    // ****************
    localparam int CLK_NS = 100;
    localparam int POR_US = 5000;
    localparam int POR_CYC = POR_US * 1000 / CLK_NS;
    localparam int SETTLE_NS = 100;
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int GUARD_CYC = 4;
    // ****************
    // opcodes
    // ****************
    localparam logic [7:0] OPC_READ1 = 8'h00;
    localparam logic [7:0] OPC_READ2 = 8'h30;
    localparam logic [7:0] OPC_PROG1 = 8'h80;
    localparam logic [7:0] OPC_PROG2 = 8'h10;
    localparam logic [7:0] OPC_ERASE1 = 8'h60;
    localparam logic [7:0] OPC_ERASE2 = 8'hd0;
    localparam logic [7:0] OPC_STATUS = 8'h70;
    localparam logic [7:0] OPC_RESET = 8'hff;
    // ****************
    // address layout, byte-wide part
    // ****************
    localparam int COL_W = 13;
    localparam int ROW_W = 18;
    localparam int PG_LSB = 0;
    localparam int PG_W = 6;
    localparam int BLK_LSB = 6;
    localparam int BLK_W = 12;
    localparam int LEN_W = 13;
    localparam logic [2:0] ADR_COL0 = 3'h0;
    localparam logic [2:0] ADR_ROW0 = 3'h2;
    localparam logic [2:0] ADR_LAST = 3'h4;
    // ****************
    // fifo shape and user operations
    // ****************
    localparam int FIFO_W = 8;
    localparam int FIFO_D = 32;
    typedef enum logic [2:0] {OP_READ, OP_PROG, OP_ERASE, OP_STATUS, OP_RESET} nfc_op_t;
endpackage

// File: bench/nfc_flash_model.sv
/*
 * behavioural byte-wide flash device for the host bench.
 * assumes the bench resolves the shared i/o; ready/busy is driven high and low by the model.
 */
`timescale 1ns/1ps
module nfc_flash_model #(
    parameter int INIT_NS = 3000,
    parameter int SETTLE_NS = 100
) (
    // strobes and selects from the host
    input wire logic i_ce_n,
    input wire logic i_cle,
    input wire logic i_ale,
    input wire logic i_we_n,
    input wire logic i_re_n,
    input wire logic i_wp_n,
    input wire logic [7:0] i_io,
    input wire logic i_slow,
    // device side
    output logic [7:0] o_io = 8'h00,
    output logic o_rb_n,
    output logic o_viol = 1'b0
);
    logic [7:0] mem [int];
    logic [7:0] pg [int];
    int kill_q [$];
    logic [7:0] cmd_reg = 8'h00;
    logic [12:0] col_reg = 13'h0000;
    logic [17:0] row_reg = 18'h00000;
    logic busy_reg = 1'b1;
    logic fail_reg = 1'b0;
    logic stat_reg = 1'b0;
    int acnt = 0;
    int ns = 0;
    int last_blk = -1;
    int last_pg = -1;
    realtime wp_t = 0;
    // busy through power-up init, ready/busy driven both high and low
    initial #(INIT_NS) busy_reg = 1'b0;
    assign o_rb_n = ~busy_reg;
    task automatic hold_busy(input int t);
        busy_reg = 1'b1;
        #(i_slow ? t * 5 : t);
        busy_reg = 1'b0;
    endtask
    // confirm needs its own setup and all address cycles
    function automatic int seq(input logic [7:0] setup);
        if (acnt < 5 || cmd_reg != setup) o_viol = 1'b1;
        return 0;
    endfunction
    // page register to array, refused while protected
    function automatic int commit();
        if (!i_wp_n) fail_reg = 1'b1;
        if (row_reg[17:6] == last_blk && row_reg[5:0] <= last_pg) o_viol = 1'b1;
        if (i_wp_n) foreach (pg[c]) mem[{row_reg, c[12:0]}] = pg[c];
        last_blk = row_reg[17:6];
        last_pg = row_reg[5:0];
        return 1000;
    endfunction
    // whole block back to ones
    function automatic int wipe();
        if (!i_wp_n) fail_reg = 1'b1;
        kill_q.delete();
        if (i_wp_n) foreach (mem[k]) if (k[30:19] == row_reg[17:6]) kill_q.push_back(k);
        foreach (kill_q[j]) mem.delete(kill_q[j]);
        if (row_reg[17:6] == last_blk) last_blk = -1;
        return 2000;
    endfunction
    // protect low at power-up, moved only while idle
    always @(i_wp_n)
    begin
        if ($time < INIT_NS ? i_wp_n === 1'b1 : (busy_reg || !i_ce_n)) o_viol = 1'b1;
        wp_t = $realtime;
    end
    // command, address or data taken on strobe rise
    always @(posedge i_we_n)
    begin
        ns = 0;
        if (!i_ce_n && i_cle)
        begin
            if (busy_reg && i_io != 8'h70) o_viol = 1'b1;
            if ($realtime - wp_t < SETTLE_NS) o_viol = 1'b1;
            if (i_io == 8'h80) pg.delete();
            stat_reg = (i_io == 8'h70);
            case (i_io)
                8'h00, 8'h80: acnt = 0;
                8'h60: acnt = 2; // row cycles only
                8'h30: ns = seq(8'h00) + 300;
                8'h10: ns = seq(8'h80) + commit();
                8'hd0: ns = seq(8'h60) + wipe();
                8'hff: ns = 500;
                8'h70: ns = 0;
                default: o_viol = 1'b1;
            endcase
            cmd_reg = i_io;
            if (ns > 0) hold_busy(ns);
        end
        else if (!i_ce_n && i_ale)
        begin
            if ((acnt == 1 && i_io[7:5] != 3'h0) || (acnt == 4 && i_io[7:2] != 6'h00)) o_viol = 1'b1;
            case (acnt)
                0: col_reg[7:0] = i_io;
                1: col_reg[12:8] = i_io[4:0];
                2: row_reg[7:0] = i_io;
                3: row_reg[15:8] = i_io;
                4: row_reg[17:16] = i_io[1:0];
                default: ; // surplus cycles dropped
            endcase
            acnt++;
        end
        else if (!i_ce_n)
        begin
            pg[col_reg] = i_io;
            col_reg++;
        end
    end
    // next byte on read strobe fall
    always @(negedge i_re_n)
    begin
        if (!i_ce_n)
        begin
            o_io = stat_reg ? {i_wp_n, ~busy_reg, 5'h00, fail_reg} : 8'hff;
            if (!stat_reg && mem.exists({row_reg, col_reg})) o_io = mem[{row_reg, col_reg}];
            col_reg += 13'(!stat_reg);
        end
    end
    // released bus shows no stale value
    always @(posedge i_re_n or posedge i_ce_n)
        o_io = ~o_io;
endmodule

// File: bench/nfc_host_bench.sv
/*
 * self-checking bench for the nand host controller.
 * assumes the behavioural flash model and a 10 mhz clock.
 */
`timescale 1ns/1ps
module nfc_host_bench;
    logic i_clk = 1'b0, i_rstn = 1'b0, i_cmd_valid = 1'b0, i_protect = 1'b1, i_wr_valid = 1'b0, slow = 1'b0;
    nfc_pkg::nfc_op_t i_cmd_op = nfc_pkg::OP_STATUS;
    logic [12:0] i_col = 13'h0, i_len = 13'h0;
    logic [17:0] i_row = 18'h00000;
    logic [7:0] i_wr_data = 8'h00, o_rd_data, o_io, dev_io, rd_q [$], wr_q [$];
    logic [7:0] ref_mem [int];
    logic o_cmd_ready, o_done, o_err, o_wr_ready, o_rd_valid, o_ce_n, o_cle, o_ale, o_we_n, o_re_n;
    logic o_wp_n, o_io_oe, rb_n, viol, took = 1'b0;
    logic [31:0] seed = 32'h30da4f38;
    int num_errors = 0, compares = 0, cycles = 0;
    wire logic [7:0] bus_io = o_io_oe ? o_io : dev_io;
    nfc_host #(.POR_CYC(20)) nfc_host_i (.i_clk, .i_rstn, .i_cmd_valid, .i_cmd_op, .i_col, .i_row, .i_len,
        .i_protect, .o_cmd_ready, .o_done, .o_err, .i_wr_data, .i_wr_valid, .o_wr_ready, .o_rd_data,
        .o_rd_valid, .o_ce_n, .o_cle, .o_ale, .o_we_n, .o_re_n, .o_wp_n, .o_io, .o_io_oe,
        .i_io(bus_io), .i_rb_n(rb_n));
    nfc_flash_model nfc_flash_model_i (.i_ce_n(o_ce_n), .i_cle(o_cle), .i_ale(o_ale), .i_we_n(o_we_n),
        .i_re_n(o_re_n), .i_wp_n(o_wp_n), .i_io(bus_io), .i_slow(slow), .o_io(dev_io),
        .o_rb_n(rb_n), .o_viol(viol));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [7:0] expb(input int k);
        return ref_mem.exists(k) ? ref_mem[k] : 8'hff;
    endfunction
    task automatic check(input logic [31:0] seen, exp, input string what);
        compares++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // clock, fifo handshake sampling and hang guard
    always #50 i_clk = ~i_clk;
    always @(posedge i_clk)
    begin
        took <= i_wr_valid && o_wr_ready;
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            num_errors++;
            finish_test();
        end
    end
    // write data feeder with gaps
    always @(negedge i_clk)
    begin
        if (took) void'(wr_q.pop_front());
        if (!i_wr_valid || took) i_wr_valid = wr_q.size() > 0 && cycles % 3 != 0;
        if (wr_q.size() > 0) i_wr_data = wr_q[0];
    end
    task automatic run(input nfc_pkg::nfc_op_t op, input logic [17:0] row = '0, input logic [12:0] col = '0,
            input logic [12:0] len = '0, input logic exp_err = 1'b0);
        int n;
        n = 0;
        rd_q.delete();
        @(negedge i_clk);
        while (n < 200 && (o_cmd_ready !== 1'b1 || o_wp_n !== !i_protect))
        begin
            @(negedge i_clk);
            n++;
        end
        i_cmd_op = op;
        i_row = row;
        i_col = col;
        i_len = len;
        i_cmd_valid = 1'b1;
        @(negedge i_clk);
        i_cmd_valid = 1'b0;
        while (n < 20000 && o_done !== 1'b1 && o_err !== 1'b1)
        begin
            @(negedge i_clk);
            n++;
            if (o_rd_valid === 1'b1) rd_q.push_back(o_rd_data);
        end
        check({n >= 20000, o_err}, {1'b0, exp_err}, "command outcome");
    endtask
    task automatic prog(input logic [17:0] row, input logic [12:0] col, input int len, input logic exp_err);
        logic [7:0] b;
        for (int i = 0; i < len && !exp_err; i++)
        begin
            b = 8'(rnd());
            wr_q.push_back(b);
            ref_mem[{row, col + 13'(i)}] = b;
        end
        if (len == 40)
        begin
            repeat (80) @(negedge i_clk);
            check(wr_q.size(), 8, "fifo fill");
            check(o_wr_ready, 0, "fifo full");
        end
        run(nfc_pkg::OP_PROG, row, col, 13'(len), exp_err);
    endtask
    task automatic rdback(input logic [17:0] row, input logic [12:0] col, input int len);
        run(nfc_pkg::OP_READ, row, col, 13'(len), 1'b0);
        check(rd_q.size(), len, "read length");
        foreach (rd_q[i]) check(rd_q[i], expb({row, col + 13'(i)}), "read byte");
    endtask
    task automatic erase(input logic [17:0] row);
        int ks [$];
        run(nfc_pkg::OP_ERASE, row);
        foreach (ref_mem[k]) if (k[30:19] == row[17:6]) ks.push_back(k);
        foreach (ks[j]) ref_mem.delete(ks[j]);
    endtask
    // main sequence
    initial
    begin
        logic [31:0] r;
        logic [17:0] row;
        int len;
        repeat (5) @(negedge i_clk);
        check({o_ce_n, o_we_n, o_wp_n, o_io_oe, o_cmd_ready}, 5'h18, "reset pins");
        i_rstn = 1'b1;
        run(nfc_pkg::OP_STATUS);
        check($time > 3000, 1, "early ready");
        check(rd_q[0], 8'h40, "status protected");
        prog(18'h00140, 13'h0, 4, 1'b1);
        run(nfc_pkg::OP_ERASE, 18'h00140, 13'h0, 13'h0, 1'b1);
        i_protect = 1'b0;
        run(nfc_pkg::OP_STATUS);
        check(rd_q[0], 8'hc0, "status open");
        for (int i = 0; i < 8; i++)
        begin
            r = rnd();
            row = r[17:0];
            len = (i == 0) ? 256 : 1 + r[23:18];
            slow = i[0];
            erase(row);
            prog(row, (i == 0) ? 13'h1000 : 13'(rnd() % (4353 - len)), len, 1'b0);
            rdback(row, (i == 0) ? 13'h1000 : i_col, len);
        end
        row[5:0] = 6'h3e;
        erase(row);
        prog(row, 13'h0, 2, 1'b0);
        prog(row, 13'h0, 2, 1'b1);
        prog({row[17:6], 6'h05}, 13'h0, 2, 1'b1);
        prog({row[17:6], 6'h3f}, 13'h0010, 3, 1'b0);
        erase(row ^ 18'h20000);
        prog(row ^ 18'h20000, 13'h0010, 3, 1'b0);
        rdback({row[17:6], 6'h3f}, 13'h0010, 3);
        rdback(row ^ 18'h20000, 13'h0010, 3);
        erase(18'h00380);
        prog(18'h00380, 13'h0, 40, 1'b0);
        rdback(18'h00380, 13'h0, 40);
        check(o_wr_ready, 1, "fifo drained");
        run(nfc_pkg::OP_RESET);
        check(viol, 0, "device rules");
        finish_test();
    end
endmodule
